// [hdl/ptm_bank.sv]
// Purpose: Protection measurement register bank read by a supervisor
// Assumes: Inputs synchronous to clk_sys; register port strobes one cycle
// Notes:   Answers one cycle after each strobe with data or an exception
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Each applied setting change, local or remote, bumps a 16-bit counter.
// - Switches moved while unpowered bump the counter once after power-up.
// - Per conductor, the largest trip current is kept, 0x8000 when none.
// - Trip maxima only update with auxiliary power and a breaker code.
// - Phase load is a whole percent of long-time pickup, up to 32767.
// - Neutral load is a percent of rated current times the neutral factor.
// - Neutral load is unavailable when no external current transformer.
// - Ground fault and earth leakage are percents of their pickups.
// - Battery reads 100 above 2800 mV, 50 between, 0 below 2200 mV.
// - The long-time countdown is refreshed once per second.
// - The countdown keeps refreshing after any other protection trips.
// - The countdown is tenths of seconds over two modulo-10000 words.
// - Language uses one bit per language, bit 6 and bits 10-15 reserved.
// - The local keypad can also change the language.
// - Frequency bit 3 (400 Hz) disables phase rotation protection.
// - Frequency bit 0 (50/60 Hz) is selected out of reset.
module ptm_bank
	import ptm_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)(
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	input  wire logic                         ce,

	input  wire logic [15:0]                  reg_addr,
	input  wire logic                         reg_rd,
	input  wire logic                         reg_wr,
	input  wire logic [15:0]                  reg_wdata,
	output var  logic [15:0]                  reg_rdata,
	output var  logic                         reg_ack,
	output var  logic                         reg_err,

	input  wire logic                         setting_applied,
	input  wire logic                         switches_moved_offline,
	input  wire logic                         aux_power_ok,
	input  wire logic                         breaker_code_valid,
	input  wire logic                         trip_valid,
	input  wire logic [PHASE_COUNT-1:0][15:0] trip_current,
	input  wire logic                         clear_max,

	input  wire logic [PHASE_COUNT-1:0][15:0] load_pct,
	input  wire logic                         neutral_ct_absent,
	input  wire logic [15:0]                  ground_fault_pct_in,
	input  wire logic [15:0]                  earth_leakage_pct_in,
	input  wire logic [15:0]                  battery_mv,

	input  wire logic [31:0]                  long_time_remaining,
	input  wire logic                         phase_sequence_in,

	input  wire logic                         panel_lang_wr,
	input  wire logic [15:0]                  panel_lang_data,
	output var  logic [15:0]                  display_language,
	output var  logic [15:0]                  network_frequency,
	output var  logic                         phase_rotation_prot_en
);

	// -----------------------------------------------------------------
	// Parameter checks
	// -----------------------------------------------------------------
	if (TICK_LEN < 2) begin : g_bad_tick
		$error("TICK_LEN must be at least 2");
	end

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [15:0]                  change_cnt;
		logic                         started;

		logic [PHASE_COUNT-1:0][15:0] load;
		logic [15:0]                  gf_pct;
		logic [15:0]                  el_pct;
		logic [15:0]                  batt;
		logic [15:0]                  phase_seq;
		logic [15:0]                  lang;
		logic [15:0]                  freq;
		logic                         rot_en;

		logic [31:0]                  tick_cnt;
		logic                         tick;
		logic [15:0]                  rdata;
		logic                         ack;
		logic                         err;
	} ptm_bank_state_t;

	localparam logic [31:0] TICK_LAST = 32'(TICK_LEN - 1);

	ptm_bank_state_t st_q;
	ptm_bank_state_t st_d;

	logic [PHASE_COUNT-1:0][15:0] peak;
	logic                         max_enable;
	logic [15:0]                  lt_lo;
	logic [15:0]                  lt_hi;

	ptm_peak_if pk_if [PHASE_COUNT] ();

	// -----------------------------------------------------------------
	// Maximum trip current holders
	// -----------------------------------------------------------------
	// power and code present
	assign max_enable = aux_power_ok && breaker_code_valid;

	for (genvar g = 0; g < PHASE_COUNT; g++) begin : g_peak
		assign pk_if[g].enable       = max_enable;
		assign pk_if[g].clear        = clear_max;
		assign pk_if[g].sample_valid = trip_valid;
		assign pk_if[g].sample       = trip_current[g];
		assign peak[g]               = pk_if[g].peak;

		ptm_peak_hold u_peak (
			.clk_sys (clk_sys),
			.rst_n   (rst_n),
			.ce      (ce),
			.pk      (pk_if[g])
		);
	end

	// -----------------------------------------------------------------
	// Long-time countdown words
	// -----------------------------------------------------------------
	// words load one cycle after each tick
	ptm_mod_split u_split (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.ce        (ce),
		.load      (st_q.tick),
		.value     (long_time_remaining),
		.low_word  (lt_lo),
		.high_word (lt_hi)
	);

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.ack = 1'b0;
		st_d.err = 1'b0;

		if (setting_applied) begin
			st_d.change_cnt = st_d.change_cnt + 16'h0001;
		end
		if (!st_q.started) begin
			st_d.started = 1'b1;
			if (switches_moved_offline) begin
				st_d.change_cnt = st_d.change_cnt + 16'h0001;
			end
		end

		for (int i = 0; i < PHASE_COUNT; i++) begin
			st_d.load[i] = (load_pct[i] > LOAD_PCT_LIMIT) ?
				LOAD_PCT_LIMIT : load_pct[i];
		end
		if (neutral_ct_absent) begin
			st_d.load[PHASE_COUNT-1] = NOT_AVAILABLE;
		end

		st_d.gf_pct = (ground_fault_pct_in > LOAD_PCT_LIMIT) ?
			LOAD_PCT_LIMIT : ground_fault_pct_in;
		st_d.el_pct = (earth_leakage_pct_in > LOAD_PCT_LIMIT) ?
			LOAD_PCT_LIMIT : earth_leakage_pct_in;

		if (battery_mv > BATT_HIGH_MV) begin
			st_d.batt = BATT_FULL;
		end else if (battery_mv >= BATT_LOW_MV) begin
			st_d.batt = BATT_HALF;
		end else begin
			st_d.batt = BATT_EMPTY;
		end

		st_d.phase_seq = {15'h0000, phase_sequence_in};

		st_d.tick = 1'b0;
		if (st_q.tick_cnt >= TICK_LAST) begin
			st_d.tick_cnt = 32'h0000_0000;
			st_d.tick = 1'b1;
		end else begin
			st_d.tick_cnt = st_q.tick_cnt + 32'h0000_0001;
		end

		if (panel_lang_wr) begin
			st_d.lang = panel_lang_data & LANG_WRITE_MASK;
		end

		// Register port; a read sees the previous cycle's samples
		if (reg_rd || reg_wr) begin
			st_d.ack = 1'b1;
			st_d.rdata = 16'h0000;
			if (reg_wr) begin
				case (reg_addr)
					ADDR_DISPLAY_LANGUAGE: begin
						if (!panel_lang_wr) begin
							st_d.lang = reg_wdata & LANG_WRITE_MASK;
						end
					end

					ADDR_NETWORK_FREQUENCY_SELECT: begin
						st_d.freq = reg_wdata & FREQ_WRITE_MASK;
					end

					default: begin
						st_d.err = 1'b1;
					end
				endcase
			end else begin
				case (reg_addr)
					ADDR_SETTING_CHANGE_COUNTER: begin
						st_d.rdata = st_q.change_cnt;
					end

					ADDR_MAX_TRIP_CURRENT_PHASE1: begin
						st_d.rdata = peak[0];
					end

					ADDR_MAX_TRIP_CURRENT_PHASE2: begin
						st_d.rdata = peak[1];
					end

					ADDR_MAX_TRIP_CURRENT_PHASE3: begin
						st_d.rdata = peak[2];
					end

					ADDR_MAX_TRIP_CURRENT_NEUTRAL: begin
						st_d.rdata = peak[3];
					end

					ADDR_LOAD_PCT_PHASE1: begin
						st_d.rdata = st_q.load[0];
					end

					ADDR_LOAD_PCT_PHASE2: begin
						st_d.rdata = st_q.load[1];
					end

					ADDR_LOAD_PCT_PHASE3: begin
						st_d.rdata = st_q.load[2];
					end

					ADDR_LOAD_PCT_NEUTRAL: begin
						st_d.rdata = st_q.load[3];
						st_d.err = neutral_ct_absent;
					end

					ADDR_GROUND_FAULT_PCT: begin
						st_d.rdata = st_q.gf_pct;
					end

					ADDR_EARTH_LEAKAGE_PCT: begin
						st_d.rdata = st_q.el_pct;
					end

					ADDR_BATTERY_CHARGE_LEVEL: begin
						st_d.rdata = st_q.batt;
					end

					ADDR_LONG_TIME_TRIP_COUNTDOWN: begin
						st_d.rdata = lt_lo;
					end

					ADDR_LONG_TIME_TRIP_COUNTDOWN_HI: begin
						st_d.rdata = lt_hi;
					end

					ADDR_PHASE_SEQUENCE: begin
						st_d.rdata = st_q.phase_seq;
					end

					ADDR_DISPLAY_LANGUAGE: begin
						st_d.rdata = st_q.lang;
					end

					ADDR_NETWORK_FREQUENCY_SELECT: begin
						st_d.rdata = st_q.freq;
					end

					default: begin
						st_d.err = 1'b1;
					end
				endcase
			end
		end

		st_d.rot_en = !st_d.freq[FREQ_400HZ_BIT];
	end

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q            <= '0;
			st_q.lang       <= LANG_RESET;
			st_q.freq       <= FREQ_RESET;
			st_q.rot_en     <= 1'b1;
			st_q.batt       <= BATT_EMPTY;
			for (int i = 0; i < PHASE_COUNT; i++) begin
				st_q.load[i] <= 16'h0000;
			end
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign reg_rdata              = st_q.rdata;
	assign reg_ack                = st_q.ack;
	assign reg_err                = st_q.err;

	assign display_language       = st_q.lang;
	assign network_frequency      = st_q.freq;
	assign phase_rotation_prot_en = st_q.rot_en;

endmodule : ptm_bank
`default_nettype wire

// [hdl/ptm_mod_split.sv]
// Purpose: Splits a binary count into two modulo ten thousand words
// Assumes: Load is a one-cycle strobe
// Notes:   Values past 99999999 saturate both words at 9999
`timescale 1ns/1ns
`default_nettype none
module ptm_mod_split
	import ptm_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        load,
	input  wire logic [31:0] value,
	output var  logic [15:0] low_word,
	output var  logic [15:0] high_word
);
	typedef struct packed {
		logic [15:0] lo;
		logic [15:0] hi;
	} ptm_split_state_t;

	ptm_split_state_t st_q;
	ptm_split_state_t st_d;
	logic [31:0]      quot;
	logic [31:0]      rem;

	always_comb begin
		st_d = st_q;
		// Constant divisor keeps this a fixed combinational network
		quot = value / MOD_BASE;
		rem  = value % MOD_BASE;
		if (load) begin
			if (quot > {16'h0000, MOD_DIGIT_MAX}) begin
				st_d.lo = MOD_DIGIT_MAX;
				st_d.hi = MOD_DIGIT_MAX;
			end else begin
				st_d.lo = rem[15:0];
				st_d.hi = quot[15:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign low_word  = st_q.lo;
	assign high_word = st_q.hi;
endmodule : ptm_mod_split
`default_nettype wire

// [hdl/ptm_peak_hold.sv]
// Purpose: Holds the largest trip current of one conductor
// Assumes: Samples already in tenths of a percent of rated current
// Notes:   Reads the no-fault code until a valid trip is recorded
`timescale 1ns/1ns
`default_nettype none
module ptm_peak_hold
	import ptm_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic ce,
	ptm_peak_if.hold  pk
);
	typedef struct packed {
		logic [15:0] peak;
	} ptm_peak_state_t;

	ptm_peak_state_t st_q;
	ptm_peak_state_t st_d;
	logic [15:0]     clamped;

	always_comb begin
		st_d = st_q;
		clamped = (pk.sample > MAX_TRIP_LIMIT) ? MAX_TRIP_LIMIT : pk.sample;
		if (pk.clear) begin
			st_d.peak = MAX_TRIP_NO_FAULT;
		end else if (pk.sample_valid && pk.enable) begin
			if (st_q.peak == MAX_TRIP_NO_FAULT || clamped > st_q.peak) begin
				st_d.peak = clamped;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q <= '{peak: MAX_TRIP_NO_FAULT};
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign pk.peak = st_q.peak;
endmodule : ptm_peak_hold
`default_nettype wire

// [hdl/ptm_peak_if.sv]
// Purpose: Carrier between the bank and one maximum trip current holder
// Assumes: One clock domain, driven by the bank
// Notes:   The holder owns only the peak value
`timescale 1ns/1ns
`default_nettype none
interface ptm_peak_if;
	logic        enable;
	logic        clear;
	logic        sample_valid;
	logic [15:0] sample;
	logic [15:0] peak;
	modport hold (input enable, clear, sample_valid, sample, output peak);
	modport user (output enable, clear, sample_valid, sample, input peak);
endinterface : ptm_peak_if
`default_nettype wire

// [hdl/ptm_pkg.sv]
// Purpose: Shared constants for the protection measurement register bank
// Assumes: 16-bit register words, word addresses as on the register port
// Notes:   Timing counts derive from the clock period and the tick time
package ptm_pkg;

	// -----------------------------------------------------------------
	// Register addresses
	// -----------------------------------------------------------------
	localparam logic [15:0] ADDR_SETTING_CHANGE_COUNTER   = 16'h2263;
	localparam logic [15:0] ADDR_MAX_TRIP_CURRENT_PHASE1  = 16'h2280;
	localparam logic [15:0] ADDR_MAX_TRIP_CURRENT_PHASE2  = 16'h2281;
	localparam logic [15:0] ADDR_MAX_TRIP_CURRENT_PHASE3  = 16'h2282;
	localparam logic [15:0] ADDR_MAX_TRIP_CURRENT_NEUTRAL = 16'h2283;
	localparam logic [15:0] ADDR_LOAD_PCT_PHASE1          = 16'h2284;
	localparam logic [15:0] ADDR_LOAD_PCT_PHASE2          = 16'h2285;
	localparam logic [15:0] ADDR_LOAD_PCT_PHASE3          = 16'h2286;
	localparam logic [15:0] ADDR_LOAD_PCT_NEUTRAL         = 16'h2287;
	localparam logic [15:0] ADDR_GROUND_FAULT_PCT         = 16'h2288;
	localparam logic [15:0] ADDR_EARTH_LEAKAGE_PCT        = 16'h2289;
	localparam logic [15:0] ADDR_BATTERY_CHARGE_LEVEL     = 16'h228a;
	localparam logic [15:0] ADDR_LONG_TIME_TRIP_COUNTDOWN = 16'h22a0;
	localparam logic [15:0] ADDR_LONG_TIME_TRIP_COUNTDOWN_HI = 16'h22a1;
	localparam logic [15:0] ADDR_PHASE_SEQUENCE           = 16'h22a7;
	localparam logic [15:0] ADDR_DISPLAY_LANGUAGE         = 16'h258d;
	localparam logic [15:0] ADDR_NETWORK_FREQUENCY_SELECT = 16'h258e;

	// -----------------------------------------------------------------
	// Values, limits and field layouts
	// -----------------------------------------------------------------
	localparam logic [15:0] MAX_TRIP_NO_FAULT   = 16'h8000;
	localparam logic [15:0] MAX_TRIP_LIMIT      = 16'h3e80;
	localparam logic [15:0] LOAD_PCT_LIMIT      = 16'h7fff;
	localparam logic [15:0] NOT_AVAILABLE       = 16'h8000;
	localparam logic [15:0] BATT_HIGH_MV        = 16'h0af0;
	localparam logic [15:0] BATT_LOW_MV         = 16'h0898;
	localparam logic [15:0] BATT_FULL           = 16'h0064;
	localparam logic [15:0] BATT_HALF           = 16'h0032;
	localparam logic [15:0] BATT_EMPTY          = 16'h0000;
	localparam logic [31:0] MOD_BASE            = 32'h0000_2710;
	localparam logic [15:0] MOD_DIGIT_MAX       = 16'h270f;
	localparam logic [15:0] LANG_WRITE_MASK     = 16'h03bf;
	localparam logic [15:0] LANG_RESET          = 16'h0004;
	localparam logic [15:0] FREQ_WRITE_MASK     = 16'h0009;
	localparam logic [15:0] FREQ_RESET          = 16'h0001;
	localparam int          FREQ_400HZ_BIT      = 3;
	localparam int          PHASE_COUNT         = 4;

	// -----------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 50;
	localparam int TICK_PERIOD_MS = 1000;
	localparam int TICK_CYCLES    = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

endpackage : ptm_pkg

// [sim/ptm_bank_asserts.sv]
// Purpose: Port-level checks of the measurement register bank
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound into every ptm_bank instance
`timescale 1ns/1ns
`default_nettype none
module ptm_bank_asserts
	import ptm_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        ce,
	input wire logic [15:0] reg_addr,
	input wire logic        reg_rd,
	input wire logic        reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_ack,
	input wire logic        reg_err,
	input wire logic [15:0] battery_mv,
	input wire logic        panel_lang_wr,
	input wire logic [15:0] panel_lang_data,
	input wire logic [15:0] display_language,
	input wire logic [15:0] network_frequency,
	input wire logic        phase_rotation_prot_en
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	logic lang_hit, rw_hit;
	assign lang_hit = reg_wr && reg_addr == ADDR_DISPLAY_LANGUAGE;
	assign rw_hit   = lang_hit || (reg_wr && reg_addr == ADDR_NETWORK_FREQUENCY_SELECT);

	// Reads lag a cycle, so battery must stand two cycles
	sequence s_batt_rd;
		ce && reg_rd && !reg_wr && reg_addr == ADDR_BATTERY_CHARGE_LEVEL;
	endsequence
	sequence s_batt_high;
		(battery_mv > BATT_HIGH_MV) [*2];
	endsequence
	sequence s_batt_low;
		(battery_mv < BATT_LOW_MV) [*2];
	endsequence

	chk_ack_follows_req: assert property ((ce && (reg_rd || reg_wr)) |=> reg_ack)
		else $error("request not answered next cycle");
	chk_ack_needs_req: assert property (reg_ack |-> $past(ce && (reg_rd || reg_wr)))
		else $error("answer without request");
	chk_ro_write_err: assert property ((ce && reg_wr && !rw_hit) |=> reg_ack && reg_err)
		else $error("write to read-only place not refused");
	chk_lang_write: assert property ((ce && lang_hit && !panel_lang_wr) |=>
		display_language == $past(reg_wdata & LANG_WRITE_MASK) && !reg_err)
		else $error("language write not applied");
	chk_panel_lang: assert property ((ce && panel_lang_wr) |=>
		display_language == $past(panel_lang_data & LANG_WRITE_MASK))
		else $error("panel language not applied");
	chk_lang_hold: assert property ($changed(display_language) |->
		$past(ce && (panel_lang_wr || lang_hit)))
		else $error("language changed without a write");
	chk_lang_reserved: assert property ((display_language & ~LANG_WRITE_MASK) == 16'h0000)
		else $error("reserved language bit set");
	chk_freq_reserved: assert property ((network_frequency & ~FREQ_WRITE_MASK) == 16'h0000)
		else $error("reserved frequency bit set");
	chk_rot_follows_freq: assert property (phase_rotation_prot_en == !network_frequency[3])
		else $error("rotation protection not tied to 400 Hz bit");
	chk_batt_full: assert property (s_batt_high ##0 s_batt_rd |=> reg_rdata == BATT_FULL)
		else $error("battery high not read as full");
	chk_batt_empty: assert property (s_batt_low ##0 s_batt_rd |=> reg_rdata == BATT_EMPTY)
		else $error("battery low not read as empty");
endmodule : ptm_bank_asserts

bind ptm_bank ptm_bank_asserts i_ptm_bank_asserts (.*);
`default_nettype wire

// [sim/ptm_supervisor.sv]
// Purpose: Remote supervisor issuing register reads and writes
// Assumes: Caller enters access at a falling edge
// Notes:   Released address and data lines show the inverse of the last value; strobes return low
`timescale 1ns/1ns
`default_nettype none
module ptm_supervisor
	import ptm_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reg_ack,
	output var  logic [15:0] reg_addr,
	output var  logic        reg_rd,
	output var  logic        reg_wr,
	output var  logic [15:0] reg_wdata
);
	initial begin
		reg_addr  = 16'hffff;
		reg_rd    = 1'b0;
		reg_wr    = 1'b0;
		reg_wdata = 16'hffff;
	end

	// whole words written, reserved bits included
	task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] wd);
		int n;
		reg_addr  = a;
		reg_wdata = wd;
		reg_rd    = !wr;
		reg_wr    = wr;
		@(negedge clk_sys);
		reg_rd    = 1'b0;
		reg_wr    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~wd;
		for (n = 0; n < 8 && reg_ack !== 1'b1; n++) begin
			@(negedge clk_sys);
		end
		@(negedge clk_sys);
	endtask : access
endmodule : ptm_supervisor
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the measurement register bank
// Assumes: Inputs change at falling edges; clock enable held high
// Notes:   Short tick length keeps countdown tests brief
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import ptm_pkg::*;
	localparam int TLEN = 40;
	typedef struct packed {logic [15:0] data; logic err;} ptm_exp_t;

	logic                         clk_sys, rst_n, ce, reg_rd, reg_wr, reg_ack, reg_err;
	logic [15:0]                  reg_addr, reg_wdata, reg_rdata, d;
	logic                         setting_applied, switches_moved_offline, trip_valid;
	logic                         aux_power_ok, breaker_code_valid, clear_max;
	logic                         neutral_ct_absent, phase_sequence_in, panel_lang_wr;
	logic                         phase_rotation_prot_en;
	logic [PHASE_COUNT-1:0][15:0] trip_current, load_pct, v;
	logic [15:0]                  ground_fault_pct_in, earth_leakage_pct_in, battery_mv;
	logic [15:0]                  panel_lang_data, display_language, network_frequency;
	logic [31:0]                  long_time_remaining;
	ptm_exp_t                     exp_q[$];
	ptm_exp_t                     e;
	int                           n_fail, checks_done, cycles, i, k;
	integer                       seed;
	logic [15:0]                  mv_tab[4] = '{16'd2801, 16'd2800, 16'd2200, 16'd2199};
	logic [15:0]                  bt_tab[4] = '{16'd100, 16'd50, 16'd50, 16'd0};

	ptm_bank #(.TICK_LEN(TLEN)) i_ptm_bank (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
		.setting_applied(setting_applied),
		.switches_moved_offline(switches_moved_offline),
		.aux_power_ok(aux_power_ok), .breaker_code_valid(breaker_code_valid),
		.trip_valid(trip_valid), .trip_current(trip_current),
		.clear_max(clear_max), .load_pct(load_pct),
		.neutral_ct_absent(neutral_ct_absent),
		.ground_fault_pct_in(ground_fault_pct_in),
		.earth_leakage_pct_in(earth_leakage_pct_in), .battery_mv(battery_mv),
		.long_time_remaining(long_time_remaining),
		.phase_sequence_in(phase_sequence_in), .panel_lang_wr(panel_lang_wr),
		.panel_lang_data(panel_lang_data), .display_language(display_language),
		.network_frequency(network_frequency),
		.phase_rotation_prot_en(phase_rotation_prot_en));

	ptm_supervisor i_ptm_supervisor (.clk_sys(clk_sys), .reg_ack(reg_ack),
		.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// -----------------------------------------------------------------
	// Checking, verdict and hang guard
	// -----------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
		checks_done++;
		if (seen !== expv) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, expv, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// Answers matched in order against the driver's notes
	always @(negedge clk_sys) begin
		if (reg_ack === 1'b1) begin
			if (exp_q.size() == 0) check("unexpected answer", 16'h0001, 16'h0000);
			else begin
				e = exp_q.pop_front();
				check("reg_rdata", reg_rdata, e.data);
				check("reg_err", 16'(reg_err), 16'(e.err));
			end
		end
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles >= 4000) begin
			n_fail++;
			print_verdict();
		end
	end

	// -----------------------------------------------------------------
	// Stimulus helpers
	// -----------------------------------------------------------------
	task automatic rd(input logic [15:0] a, input logic [15:0] x, input logic er);
		exp_q.push_back('{x, er});
		i_ptm_supervisor.access(1'b0, a, 16'h0000);
	endtask : rd

	task automatic wr(input logic [15:0] a, input logic [15:0] wd, input logic er);
		exp_q.push_back('{16'h0000, er});
		i_ptm_supervisor.access(1'b1, a, wd);
	endtask : wr

	task automatic trip(input logic [PHASE_COUNT-1:0][15:0] t);
		trip_current = t;
		trip_valid = 1'b1;
		@(negedge clk_sys);
		trip_valid = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask : trip

	initial begin
		seed = 32744;
		{rst_n, setting_applied, aux_power_ok, breaker_code_valid, trip_valid} = '0;
		{clear_max, neutral_ct_absent, phase_sequence_in, panel_lang_wr} = '0;
		{ground_fault_pct_in, earth_leakage_pct_in, panel_lang_data} = '0;
		{n_fail, checks_done, cycles} = '0;
		ce = 1'b1;
		switches_moved_offline = 1'b1;
		trip_current = '0;
		load_pct = '0;
		battery_mv = 16'd3000;
		long_time_remaining = 32'd0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		@(negedge clk_sys);
		switches_moved_offline = 1'b0;
		rd(ADDR_DISPLAY_LANGUAGE, LANG_RESET, 1'b0);
		rd(ADDR_NETWORK_FREQUENCY_SELECT, 16'h0001, 1'b0);
		check("rot_en", 16'(phase_rotation_prot_en), 16'h0001);
		for (i = 0; i < 4; i++) rd(ADDR_MAX_TRIP_CURRENT_PHASE1 + 16'(i), 16'h8000, 1'b0);
		rd(ADDR_SETTING_CHANGE_COUNTER, 16'd1, 1'b0);
		rd(ADDR_LONG_TIME_TRIP_COUNTDOWN, 16'd0, 1'b0);
		repeat (3) begin
			setting_applied = 1'b1;
			@(negedge clk_sys);
			setting_applied = 1'b0;
			@(negedge clk_sys);
		end
		rd(ADDR_SETTING_CHANGE_COUNTER, 16'd4, 1'b0);
		// Trips ignored without power or breaker code
		for (k = 1; k < 3; k++) begin
			{aux_power_ok, breaker_code_valid} = 2'(k);
			for (i = 0; i < 4; i++) v[i] = 16'($unsigned($random(seed)) % 16000) + 16'd1;
			trip(v);
			for (i = 0; i < 4; i++) rd(ADDR_MAX_TRIP_CURRENT_PHASE1 + 16'(i), 16'h8000, 1'b0);
		end
		{aux_power_ok, breaker_code_valid} = 2'b11;
		trip(v);
		for (i = 0; i < 4; i++) trip_current[i] = v[i] - 16'd1;
		trip_current[0] = 16'd20000;
		trip(trip_current);
		v[0] = 16'd16000;
		for (i = 0; i < 4; i++) rd(ADDR_MAX_TRIP_CURRENT_PHASE1 + 16'(i), v[i], 1'b0);
		clear_max = 1'b1;
		@(negedge clk_sys);
		clear_max = 1'b0;
		rd(ADDR_MAX_TRIP_CURRENT_NEUTRAL, 16'h8000, 1'b0);
		for (i = 0; i < 4; i++) load_pct[i] = 16'($random(seed)) & 16'h7fff;
		load_pct[2] = 16'hffff;
		ground_fault_pct_in = 16'($random(seed)) & 16'h7fff;
		earth_leakage_pct_in = 16'h8001;
		repeat (2) @(negedge clk_sys);
		for (i = 0; i < 4; i++) rd(ADDR_LOAD_PCT_PHASE1 + 16'(i), (i == 2) ? 16'h7fff : load_pct[i], 1'b0);
		rd(ADDR_GROUND_FAULT_PCT, ground_fault_pct_in, 1'b0);
		rd(ADDR_EARTH_LEAKAGE_PCT, 16'h7fff, 1'b0);
		neutral_ct_absent = 1'b1;
		repeat (2) @(negedge clk_sys);
		rd(ADDR_LOAD_PCT_NEUTRAL, 16'h8000, 1'b1);
		for (i = 0; i < 4; i++) begin
			battery_mv = mv_tab[i];
			repeat (2) @(negedge clk_sys);
			rd(ADDR_BATTERY_CHARGE_LEVEL, bt_tab[i], 1'b0);
		end
		phase_sequence_in = 1'b1;
		repeat (2) @(negedge clk_sys);
		rd(ADDR_PHASE_SEQUENCE, 16'h0001, 1'b0);
		// Countdown keeps updating after another trip
		for (k = 0; k < 2; k++) begin
			long_time_remaining = (k == 0) ? 32'd12345678 : 32'd123456789;
			trip(v);
			repeat (TLEN + 3) @(negedge clk_sys);
			d = (k == 0) ? 16'h162e : 16'h270f;
			rd(ADDR_LONG_TIME_TRIP_COUNTDOWN, d, 1'b0);
			d = (k == 0) ? 16'h04d2 : 16'h270f;
			rd(ADDR_LONG_TIME_TRIP_COUNTDOWN_HI, d, 1'b0);
		end
		d = 16'($random(seed));
		wr(ADDR_DISPLAY_LANGUAGE, d, 1'b0);
		rd(ADDR_DISPLAY_LANGUAGE, d & 16'h03bf, 1'b0);
		panel_lang_data = 16'hff80;
		fork
			begin
				panel_lang_wr = 1'b1;
				@(negedge clk_sys);
				panel_lang_wr = 1'b0;
			end
			wr(ADDR_DISPLAY_LANGUAGE, 16'h0001, 1'b0);
		join
		check("language", display_language, 16'h0380);
		wr(ADDR_NETWORK_FREQUENCY_SELECT, 16'h0008, 1'b0);
		check("rot_en", 16'(phase_rotation_prot_en), 16'h0000);
		wr(ADDR_NETWORK_FREQUENCY_SELECT, 16'hffff, 1'b0);
		check("frequency", network_frequency, 16'h0009);
		wr(ADDR_NETWORK_FREQUENCY_SELECT, 16'h0001, 1'b0);
		check("rot_en", 16'(phase_rotation_prot_en), 16'h0001);
		wr(ADDR_SETTING_CHANGE_COUNTER, 16'($random(seed)), 1'b1);
		wr(ADDR_BATTERY_CHARGE_LEVEL, 16'h0064, 1'b1);
		rd(ADDR_SETTING_CHANGE_COUNTER, 16'd4, 1'b0);
		wr(16'h1234, 16'h5555, 1'b1);
		rd(16'h1234, 16'h0000, 1'b1);
		repeat (3) @(negedge clk_sys);
		check("pending answers", 16'(exp_q.size()), 16'h0000);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
